/* dv/lcdi_host_model.sv */
// bus master model: start, stop and byte writes on the two-wire bus
// assumes the bench resolves the open-drain data wire and feeds it back
`timescale 1ns/1ps
module lcdi_host_model
(
  input  wire logic sys_clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaOe
);
  // bus phase length in sys_clk cycles, above the pin synchroniser need
  localparam int HALF = 10;

  // idle bus: both lines released high
  initial
  begin
    sclOut = 1'b1;
    sdaOe  = 1'b0;
  end

  task automatic waitHalf();
    repeat (HALF) @(negedge sys_clk);
  endtask : waitHalf

  // start or repeated start; from idle the first two steps change nothing
  task automatic sendStart();
    sdaOe = 1'b0;
    waitHalf();
    sclOut = 1'b1;
    waitHalf();
    sdaOe = 1'b1;
    waitHalf();
    sclOut = 1'b0;
    waitHalf();
  endtask : sendStart

  task automatic sendStop();
    sdaOe = 1'b1;
    waitHalf();
    sclOut = 1'b1;
    waitHalf();
    sdaOe = 1'b0;
    waitHalf();
  endtask : sendStop

  // eight bits msb first, then the acknowledge slot with the line released
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaOe = ~b[i];
      waitHalf();
      sclOut = 1'b1;
      waitHalf();
      sclOut = 1'b0;
    end
    sdaOe = 1'b0;
    waitHalf();
    sclOut = 1'b1;
    waitHalf();
    ack = ~sdaLine;
    sclOut = 1'b0;
  endtask : sendByte
endmodule : lcdi_host_model

/* dv/lcdi_rx_tb.sv */
// self-checking bench for the display driver two-wire write receiver
// assumes the host model owns the bus; the bench drives straps, loads and the word sink
`timescale 1ns/1ps
module lcdi_rx_tb;
  import lcdi_pkg::*;
  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              sclPin, hostSdaOe, ackPinOut, ackPinOe, sdaPin, ack;
  logic              asel = 1'b0, ptrLoad = 1'b0, subLoad = 1'b0, wordReady = 1'b0;
  logic [1:0]        strap = 2'h0, subVal = 2'h0, subCount;
  logic [6:0]        ptrVal = 7'h00, dataPointer;
  logic              wordValid, busBusy;
  logic [WORD_W-1:0] wordData;
  int                err_count = 0, n_compared = 0, cycles = 0;

  // open-drain data wire: low while either party pulls
  assign sdaPin = ~(hostSdaOe | ackPinOe);
  always #5 sys_clk = ~sys_clk;

  lcdi_rx i_lcdi_rx (.sys_clk(sys_clk), .nrst(nrst), .sclPin(sclPin), .sdaPin(sdaPin),
    .ackPinOut(ackPinOut), .ackPinOe(ackPinOe), .addressSelectPin(asel),
    .subaddressStrapBit0(strap[0]), .subaddressStrapBit1(strap[1]), .ptrLoad(ptrLoad),
    .ptrLoadValue(ptrVal), .subLoad(subLoad), .subLoadValue(subVal), .wordValid(wordValid),
    .wordReady(wordReady), .wordData(wordData), .dataPointer(dataPointer),
    .subaddressCounter(subCount), .busBusy(busBusy));

  lcdi_host_model i_lcdi_host_model (.sys_clk(sys_clk), .sdaLine(sdaPin), .sclOut(sclPin),
    .sdaOe(hostSdaOe));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic xfer(input logic [7:0] b, input logic expAck, input string what);
    i_lcdi_host_model.sendByte(b, ack);
    check(what, expAck, ack);
  endtask : xfer

  task automatic frame(input logic [7:0] ctrl);
    i_lcdi_host_model.sendStart();
    xfer(8'h70, 1'b1, "address");
    xfer(ctrl, 1'b1, "control");
  endtask : frame

  task automatic loadCounters(input logic [6:0] p, input logic [1:0] s);
    @(negedge sys_clk);
    ptrVal = p;
    subVal = s;
    ptrLoad = 1'b1;
    subLoad = 1'b1;
    @(negedge sys_clk);
    ptrLoad = 1'b0;
    subLoad = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask : loadCounters

  // wait for a head word, compare it, then take it
  task automatic popWord(input logic [17:0] exp, input logic [17:0] mask, input string what);
    int n = 0;
    while (wordValid !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(what, exp, wordData & mask);
    wordReady = 1'b1;
    @(negedge sys_clk);
    wordReady = 1'b0;
    @(negedge sys_clk);
  endtask : popWord

  task automatic t_address();
    // {select level, ack expected, address byte}
    logic [9:0] rows [7] = '{10'h170, 10'h072, 10'h071, 10'h060, 10'h372, 10'h270, 10'h273};
    foreach (rows[i])
    begin
      asel = rows[i][9];
      repeat (10) @(negedge sys_clk);
      i_lcdi_host_model.sendStart();
      xfer(rows[i][7:0], rows[i][8], "address ack");
      check("busy", 1'b1, busBusy);
      check("ack level", 1'b0, ackPinOut);
      if (!rows[i][8])
        xfer(8'h40, 1'b0, "ignored byte");
      i_lcdi_host_model.sendStop();
      check("busy after stop", 1'b0, busBusy);
      check("line released", 1'b0, ackPinOe);
    end
    asel = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask : t_address

  task automatic t_cmd_data();
    frame(8'hbf);
    xfer(8'h12, 1'b1, "command");
    xfer(8'h7f, 1'b1, "last control");
    xfer(8'hab, 1'b1, "data 0");
    xfer(8'hcd, 1'b1, "data 1");
    i_lcdi_host_model.sendStop();
    check("pointer", 7'h02, dataPointer);
    popWord(18'h00012, 18'h200ff, "command word");
    popWord({1'b1, 2'h0, 7'h00, 8'hab}, '1, "data word 0");
    popWord({1'b1, 2'h0, 7'h01, 8'hcd}, '1, "data word 1");
  endtask : t_cmd_data

  task automatic t_restart();
    loadCounters(7'h00, 2'h0);
    frame(8'h7f);
    i_lcdi_host_model.sendStart();
    xfer(8'h72, 1'b0, "restart address");
    i_lcdi_host_model.sendStop();
    check("pointer kept", 7'h00, dataPointer);
    check("no word", 1'b0, wordValid);
  endtask : t_restart

  // fill the buffer with the sink stalled, then drain it
  task automatic t_fill();
    frame(8'h7f);
    for (int i = 0; i < 33; i++)
      xfer(i[7:0], 1'b1, "fill byte");
    xfer(8'h99, 1'b0, "full buffer");
    i_lcdi_host_model.sendStop();
    check("pointer", 7'h22, dataPointer);
    for (int i = 0; i < 33; i++)
      popWord({1'b1, 2'h0, i[6:0], i[7:0]}, '1, "drained word");
    check("empty", 1'b0, wordValid);
  endtask : t_fill

  task automatic t_subaddr();
    // {strap, selected subaddress, ack expected}
    logic [4:0] rows [3] = '{5'h02, 5'h15, 5'h0b};
    foreach (rows[i])
    begin
      strap = rows[i][4:3];
      loadCounters(7'h10, rows[i][2:1]);
      frame(8'h7f);
      xfer(8'h55, rows[i][0], "subaddress ack");
      i_lcdi_host_model.sendStop();
      check("pointer", 7'h11, dataPointer);
      if (rows[i][0])
        popWord({1'b1, rows[i][2:1], 7'h10, 8'h55}, '1, "sub word");
      else
        check("no word", 1'b0, wordValid);
    end
    strap = 2'h0;
  endtask : t_subaddr

  task automatic t_wrap();
    loadCounters(7'h4f, 2'h0);
    frame(8'h7f);
    xfer(8'h3c, 1'b1, "last place");
    xfer(8'h3d, 1'b0, "next subaddress");
    i_lcdi_host_model.sendStop();
    check("pointer wrap", 7'h01, dataPointer);
    check("sub advance", 2'h1, subCount);
    popWord({1'b1, 2'h0, 7'h4f, 8'h3c}, '1, "wrap word");
  endtask : t_wrap

  // display byte under a continuing control byte, then commands under a last one
  task automatic t_ctrl_mix();
    loadCounters(7'h05, 2'h0);
    frame(8'hc0);
    xfer(8'h44, 1'b1, "display then control");
    xfer(8'h3f, 1'b1, "control after data");
    xfer(8'h21, 1'b1, "command 0");
    xfer(8'h22, 1'b1, "command 1");
    i_lcdi_host_model.sendStop();
    check("pointer", 7'h06, dataPointer);
    popWord({1'b1, 2'h0, 7'h05, 8'h44}, '1, "mixed display word");
    popWord(18'h00021, 18'h200ff, "mixed command 0");
    popWord(18'h00022, 18'h200ff, "mixed command 1");
    check("mixed empty", 1'b0, wordValid);
  endtask : t_ctrl_mix

  // reset, then the scenarios in order
  initial
  begin
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    check("reset ackOe", 1'b0, ackPinOe);
    check("reset pointer", 7'h00, dataPointer);
    check("reset busy", 1'b0, busBusy);
    repeat (5) @(negedge sys_clk);
    t_address();
    t_cmd_data();
    t_restart();
    t_fill();
    t_subaddr();
    t_wrap();
    t_ctrl_mix();
    print_verdict();
  end
endmodule : lcdi_rx_tb

/* src/lcdi_fifo.sv */
// word fifo with a registered head so the reader sees flop outputs
// assumes DEPTH is a power of two; reader and writer share sys_clk
`timescale 1ns/1ps
module lcdi_fifo
  import lcdi_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int unsigned AW         = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrIdx;
    logic [AW-1:0]               rdIdx;
    logic [AW:0]                 count;
    logic [WIDTH-1:0]            head;
    logic                        headValid;
  } lcdi_fifo_state_t;

  lcdi_fifo_state_t s_q;
  lcdi_fifo_state_t s_d;
  logic             push;
  logic             load;

  // storage write, head refill and occupancy
  always_comb
  begin
    s_d  = s_q;
    push = inValid && (s_q.count != FULL_COUNT);
    load = (s_q.count != '0) && (!s_q.headValid || outReady);
    if (push)
    begin
      s_d.mem[s_q.wrIdx] = inData;
      s_d.wrIdx          = s_q.wrIdx + 1'b1;
    end
    if (load)
    begin
      s_d.head      = s_q.mem[s_q.rdIdx];
      s_d.rdIdx     = s_q.rdIdx + 1'b1;
      s_d.headValid = 1'b1;
    end
    else if (outReady)
    begin
      s_d.headValid = 1'b0;
    end
    s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign inReady  = (s_q.count != FULL_COUNT);
  assign outValid = s_q.headValid;
  assign outData  = s_q.head;

endmodule : lcdi_fifo

/* src/lcdi_pkg.sv */
// shared constants and types for the display driver two-wire write front end
// assumes one 100 MHz clock domain; bus pins arrive asynchronously
package lcdi_pkg;

  // address byte layout: fixed prefix in bits 7..2, select in 1, direction in 0
  localparam logic [5:0]  ADDR_PREFIX   = 6'h1c;
  localparam int unsigned ADDR_SEL_POS  = 1;
  localparam int unsigned ADDR_RW_POS   = 0;

  // control byte layout
  localparam int unsigned CTRL_CONT_POS = 7;
  localparam int unsigned CTRL_RS_POS   = 6;

  // bits per byte before the acknowledge slot
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  // display pointer range and reset values
  localparam logic [6:0]  PTR_LAST      = 7'h4f;
  localparam logic [6:0]  PTR_RESET     = 7'h00;
  localparam logic [1:0]  SUB_RESET     = 2'h0;

  // pin synchroniser bit positions
  localparam int unsigned PIN_SCL       = 0;
  localparam int unsigned PIN_SDA       = 1;
  localparam int unsigned PIN_ASEL      = 2;
  localparam int unsigned PIN_STRAP_LSB = 3;
  localparam int unsigned PIN_COUNT     = 5;

  // outgoing word: {kind, subaddress, pointer, byte}
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned WORD_W        = 18;
  localparam int unsigned WORD_KIND_POS = 17;
  localparam int unsigned WORD_SUB_LSB  = 15;
  localparam int unsigned WORD_PTR_LSB  = 8;

  // receive phases
  typedef enum logic [4:0]
  {
    PH_IDLE    = 5'h01,
    PH_ADDR    = 5'h02,
    PH_CTRL    = 5'h04,
    PH_PAYLOAD = 5'h08,
    PH_IGNORE  = 5'h10
  } lcdi_phase_t;

endpackage : lcdi_pkg

/* src/lcdi_rx.sv */
// write-only two-wire slave receiver of the display driver
// assumes bus pins and straps are asynchronous; load strobes come from sys_clk logic
// What this block does
// - slave receiver only, drives nothing but acknowledges
// - answers address prefix 0111 00x only
// - read requests are never acknowledged
// - address bit 1 must equal select pin
// - matching devices ack address, others ignore transfer
// - control byte follows the address acknowledge
// - ack holds data low through ninth clock
// - data fall/rise under clock high: start/stop
// - selection uses address, command data, strap subaddress
// - any number of bytes per transfer
// - control bit7 continues, bit6 picks data register
// - display bytes acked only on subaddress match
// - pointer advances after display bytes, subaddress when the pointer wraps
`timescale 1ns/1ps
module lcdi_rx
  import lcdi_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              sclPin,
  input  wire logic              sdaPin,
  output logic                   ackPinOut,
  output logic                   ackPinOe,
  input  wire logic              addressSelectPin,
  input  wire logic              subaddressStrapBit0,
  input  wire logic              subaddressStrapBit1,
  input  wire logic              ptrLoad,
  input  wire logic [6:0]        ptrLoadValue,
  input  wire logic              subLoad,
  input  wire logic [1:0]        subLoadValue,
  output logic                   wordValid,
  input  wire logic              wordReady,
  output logic [WORD_W-1:0]      wordData,
  output logic [6:0]             dataPointer,
  output logic [1:0]             subaddressCounter,
  output logic                   busBusy
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] meta;
    logic [PIN_COUNT-1:0] sync;
    logic                 sclPrev;
    logic                 sdaPrev;
    lcdi_phase_t          phase;
    logic [7:0]           shift;
    logic [3:0]           bitCnt;
    logic                 inAck;
    logic                 ackOe;
    logic                 ackLevel;
    logic                 ctrlMore;
    logic                 regSel;
    logic [6:0]           ptr;
    logic [1:0]           sub;
    logic                 busy;
    logic                 pushValid;
    logic [WORD_W-1:0]    pushData;
  } lcdi_rx_state_t;

  lcdi_rx_state_t s_q;
  lcdi_rx_state_t s_d;
  logic           sclS;
  logic           sdaS;
  logic           addrSelS;
  logic [1:0]     strapS;
  logic           sclRise;
  logic           sclFall;
  logic           startSeen;
  logic           stopSeen;
  logic           active;
  logic           byteEnd;
  logic           addrHit;
  logic           subHit;
  logic           fifoReady;
  logic [7:0]     rxByte;

  // synchronised pin view and bus events
  always_comb
  begin
    sclS      = s_q.sync[PIN_SCL];
    sdaS      = s_q.sync[PIN_SDA];
    addrSelS  = s_q.sync[PIN_ASEL];
    strapS    = s_q.sync[PIN_STRAP_LSB +: 2];
    rxByte    = s_q.shift;
    sclRise   = sclS && !s_q.sclPrev;
    sclFall   = !sclS && s_q.sclPrev;
    startSeen = sclS && s_q.sclPrev && !sdaS && s_q.sdaPrev;
    stopSeen  = sclS && s_q.sclPrev && sdaS && !s_q.sdaPrev;
    active    = (s_q.phase == PH_ADDR) || (s_q.phase == PH_CTRL) || (s_q.phase == PH_PAYLOAD);
    byteEnd   = active && !startSeen && !stopSeen && sclFall && !s_q.inAck && (s_q.bitCnt == BYTE_BITS);
    addrHit   = (rxByte[7:2] == ADDR_PREFIX)
                && (rxByte[ADDR_SEL_POS] == addrSelS)
                && !rxByte[ADDR_RW_POS];
    subHit    = (strapS == s_q.sub);
  end

  // receive sequencer
  always_comb
  begin
    s_d           = s_q;
    s_d.pushValid = 1'b0;
    s_d.ackLevel  = 1'b0;
    s_d.meta      = {subaddressStrapBit1, subaddressStrapBit0, addressSelectPin, sdaPin, sclPin};
    s_d.sync      = s_q.meta;
    s_d.sclPrev   = sclS;
    s_d.sdaPrev   = sdaS;
    if (startSeen)
    begin
      s_d.phase  = PH_ADDR;
      s_d.bitCnt = 4'h0;
      s_d.inAck  = 1'b0;
      s_d.ackOe  = 1'b0;
      s_d.busy   = 1'b1;
    end
    else if (stopSeen)
    begin
      s_d.phase  = PH_IDLE;
      s_d.bitCnt = 4'h0;
      s_d.inAck  = 1'b0;
      s_d.ackOe  = 1'b0;
      s_d.busy   = 1'b0;
    end
    else if (active)
    begin
      if (sclRise && !s_q.inAck)
      begin
        s_d.shift  = {s_q.shift[6:0], sdaS};
        s_d.bitCnt = s_q.bitCnt + 4'h1;
      end
      if (sclFall && s_q.inAck)
      begin
        s_d.ackOe = 1'b0;
        s_d.inAck = 1'b0;
      end
      else if (byteEnd)
      begin
        s_d.bitCnt = 4'h0;
        s_d.inAck  = 1'b1;
        case (s_q.phase)
          PH_ADDR:
          begin
            if (addrHit)
            begin
              s_d.ackOe = 1'b1;
              s_d.phase = PH_CTRL;
            end
            else
            begin
              s_d.phase = PH_IGNORE;
              s_d.inAck = 1'b0;
            end
          end
          PH_CTRL:
          begin
            s_d.ackOe    = 1'b1;
            s_d.ctrlMore = rxByte[CTRL_CONT_POS];
            s_d.regSel   = rxByte[CTRL_RS_POS];
            s_d.phase    = PH_PAYLOAD;
          end
          PH_PAYLOAD:
          begin
            s_d.phase = s_q.ctrlMore ? PH_CTRL : PH_PAYLOAD;
            if (!s_q.regSel)
            begin
              s_d.ackOe     = fifoReady;
              s_d.pushValid = fifoReady;
              s_d.pushData  = {1'b0, s_q.sub, s_q.ptr, rxByte};
            end
            else
            begin
              s_d.ackOe     = subHit && fifoReady;
              s_d.pushValid = subHit && fifoReady;
              s_d.pushData  = {1'b1, s_q.sub, s_q.ptr, rxByte};
              if (s_q.ptr == PTR_LAST)
              begin
                s_d.ptr = PTR_RESET;
                s_d.sub = s_q.sub + 2'h1;
              end
              else
              begin
                s_d.ptr = s_q.ptr + 7'h01;
              end
            end
          end
          default:
          begin
            s_d.phase = PH_IDLE;
          end
        endcase
      end
    end
    // command decoder loads take priority over auto advance
    if (ptrLoad)
      s_d.ptr = ptrLoadValue;
    if (subLoad)
      s_d.sub = subLoadValue;
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q       <= '0;
      s_q.phase <= PH_IDLE;
      s_q.ptr   <= PTR_RESET;
      s_q.sub   <= SUB_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outgoing words buffer
  lcdi_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .inValid  (s_q.pushValid),
    .inReady  (fifoReady),
    .inData   (s_q.pushData),
    .outValid (wordValid),
    .outReady (wordReady),
    .outData  (wordData)
  );

  assign ackPinOut         = s_q.ackLevel;
  assign ackPinOe          = s_q.ackOe;
  assign dataPointer       = s_q.ptr;
  assign subaddressCounter = s_q.sub;
  assign busBusy           = s_q.busy;

  // protocol checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ack_low_only: assert property (ackPinOe |-> !ackPinOut)
    else $error("acknowledge pin drives high");
  a_addr_accept: assert property (byteEnd && s_q.phase == PH_ADDR && addrHit |=> ackPinOe && s_q.phase == PH_CTRL)
    else $error("matching address not acknowledged");
  a_read_refuse: assert property (byteEnd && s_q.phase == PH_ADDR && rxByte[ADDR_RW_POS] |=> !ackPinOe)
    else $error("read request acknowledged");
  a_select_pin: assert property (byteEnd && s_q.phase == PH_ADDR && rxByte[ADDR_SEL_POS] != addrSelS
                                 |=> s_q.phase == PH_IGNORE [*2])
    else $error("select mismatch not ignored");
  a_miss_ignore: assert property (s_q.phase == PH_IGNORE && !startSeen && !stopSeen |=> !ackPinOe)
    else $error("ignored transfer acknowledged");
  a_ack_onset: assert property ($rose(ackPinOe) |-> $past(byteEnd))
    else $error("acknowledge started outside ninth clock");
  a_ack_release: assert property ($fell(ackPinOe) |-> $past(sclFall) || $past(startSeen) || $past(stopSeen))
    else $error("acknowledge released while clock high");
  a_start_restart: assert property (startSeen |=> s_q.phase == PH_ADDR && s_q.bitCnt == 4'h0 && !ackPinOe)
    else $error("start did not rearm address phase");
  a_stop_idle: assert property (stopSeen |=> s_q.phase == PH_IDLE && !busBusy && !ackPinOe)
    else $error("stop did not idle the receiver");
  a_ctrl_fields: assert property (byteEnd && s_q.phase == PH_CTRL
                                  |=> s_q.ctrlMore == $past(rxByte[7]) && s_q.regSel == $past(rxByte[6]))
    else $error("control fields not latched");
  a_no_length: assert property (byteEnd && s_q.phase == PH_PAYLOAD |=> s_q.phase inside {PH_CTRL, PH_PAYLOAD})
    else $error("payload stream cut short");
  a_sub_gate: assert property (byteEnd && s_q.phase == PH_PAYLOAD && s_q.regSel && !subHit
                               |=> !ackPinOe && !s_q.pushValid)
    else $error("display byte taken for other subaddress");
  a_ptr_step: assert property (byteEnd && s_q.phase == PH_PAYLOAD && s_q.regSel && !ptrLoad && s_q.ptr != PTR_LAST
                               |=> s_q.ptr == $past(s_q.ptr) + 7'h01)
    else $error("pointer did not advance");
  a_msb_first: assert property (sclRise && active && !s_q.inAck && !startSeen && !stopSeen
                                |=> rxByte == {$past(rxByte[6:0]), $past(sdaS)})
    else $error("bit not shifted msb first");

  c_addr_ack: cover property (byteEnd && s_q.phase == PH_ADDR && addrHit);
  c_cmd_push: cover property (s_q.pushValid && !s_q.pushData[WORD_KIND_POS]);
  c_disp_push: cover property (s_q.pushValid && s_q.pushData[WORD_KIND_POS]);
  c_restart: cover property (startSeen && s_q.busy);

endmodule : lcdi_rx
